// ### include/pwr_mode_pkg.sv
// Package: constants and carriers for the power mode and wake-up controller
// What this block does
// - Fast wake runs on sub clock meanwhile
// - Fast wake ignored leaving deep sleep
// - Crystal fast wake: sub clock until 1024
// - Fast RC oscillator ignores fast wake enable
// - Clock-on idle wakes in 1~2 cycles
// - Modes chosen by select, divider, halt, idle bits, watchdog/detector
// - Slow source stops fast oscillator, dividers
// - Slow mode waits for slow ready flag
// - Fast ready flag after stabilisation
// - Halt, no idle, no watchdog/detector: deep sleep
// - Deep sleep stops clocks, clears watchdog
// - Sleep keeps memory, registers, ports
// - Sleep sets power-down, clears timeout
// - Sub sleep keeps watchdog on sub clock
// - Idle enable picks idle by clock-keep
// - Divider codes: slow or fast divided
// - Select bit one: undivided fast clock
package pwr_mode_pkg;
  localparam int unsigned STAB_CYCLES = 1024;
  localparam int unsigned SHORT_CYCLES = 2;
  localparam logic [2:0] DIV_SLOW_A = 3'h0;
  localparam logic [2:0] DIV_SLOW_B = 3'h1;
  localparam logic [2:0] DIV_RESET = 3'h0;
  localparam logic HIGH_SEL_RESET = 1'b1;
  localparam logic IDLE_EN_RESET = 1'b1;
  localparam logic FAST_WAKE_RESET = 1'b0;
  localparam logic CLK_KEEP_RESET = 1'b0;
  localparam int unsigned CNT_W = 11;

  typedef enum logic [1:0] {
    OSC_FAST_XTAL = 2'h0,
    OSC_FAST_RC = 2'h1,
    OSC_SLOW_RC = 2'h2,
    OSC_SLOW_XTAL = 2'h3
  } osc_kind_t;

  typedef enum logic [2:0] {
    MODE_RUN = 3'h0,
    MODE_DEEP_SLEEP = 3'h1,
    MODE_SUB_SLEEP = 3'h2,
    MODE_IDLE_OFF = 3'h3,
    MODE_IDLE_ON = 3'h4,
    MODE_WAKE = 3'h5
  } pwr_state_t;

  typedef struct packed {
    logic [2:0] clock_divider_select;
    logic fast_wake_enable;
    logic idle_enable;
    logic high_speed_select;
    logic idle_clock_keep;
  } mode_ctrl_t;

  typedef struct packed {
    logic sys_clk_en;
    logic fast_osc_en;
    logic fast_div_en;
    logic sub_clk_en;
    logic timebase_en;
    logic run_on_sub;
    logic cpu_stall;
    logic [2:0] clk_route;
  } clk_ctrl_t;

  // Route codes: 0 slow, 1 fast undivided, 2..7 fast divided by 64..2
  localparam logic [2:0] ROUTE_SLOW = 3'h0;
  localparam logic [2:0] ROUTE_FAST = 3'h1;
endpackage : pwr_mode_pkg

// ### rtl/stab_counter.sv
// Stabilisation counter for a restarting oscillator
`timescale 1ns/1ns
`default_nettype none
module stab_counter
  import pwr_mode_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic start_in,
  input wire logic osc_tick_in,
  input wire logic [CNT_W-1:0] target_in,
  // Status
  output logic done_out
);
  logic [CNT_W-1:0] count_r;
  logic running_r;

  // Done is a one-cycle pulse, so a ready flag it sets can still drop in sleep
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count_r <= '0;
      running_r <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        count_r <= '0;
        running_r <= 1'b1;
      end else if (running_r && osc_tick_in) begin
        if (count_r == target_in - 1'b1) begin
          running_r <= 1'b0;
          done_out <= 1'b1;
        end
        count_r <= count_r + 1'b1;
      end
    end
  end
endmodule : stab_counter
`default_nettype wire

// ### rtl/power_mode_wakeup_control.sv
// Operating mode, clock routing and wake-up sequencing controller
`timescale 1ns/1ns
`default_nettype none
module power_mode_wakeup_control
  import pwr_mode_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Software controls
  input wire logic [2:0] clock_divider_select_in,
  input wire logic fast_wake_enable_in,
  input wire logic idle_enable_in,
  input wire logic high_speed_select_in,
  input wire logic idle_clock_keep_in,
  input wire logic ctrl_write_in,
  // System state
  input wire osc_kind_t fast_osc_kind_in,
  input wire osc_kind_t slow_osc_kind_in,
  input wire logic watchdog_on_in,
  input wire logic low_voltage_detector_on_in,
  input wire logic halt_in,
  input wire logic wake_in,
  // Oscillator ticks, from other clocks
  input wire logic fast_osc_tick_in,
  input wire logic slow_osc_tick_in,
  // Flags and controls
  output logic high_speed_ready_flag_out,
  output logic low_speed_ready_flag_out,
  output logic power_down_flag_out,
  output logic watchdog_timeout_clear_out,
  output logic watchdog_clear_out,
  output logic watchdog_stop_out,
  output logic retain_state_out,
  output pwr_state_t mode_out,
  output clk_ctrl_t clk_ctrl_out
);
  mode_ctrl_t ctrl_r;
  pwr_state_t state_r;
  pwr_state_t state_nxt;
  pwr_state_t slept_r;
  logic [1:0] fast_sync_r;
  logic [1:0] slow_sync_r;
  logic fast_tick_d_r;
  logic slow_tick_d_r;
  logic fast_edge;
  logic slow_edge;
  logic slow_mode;
  logic fast_is_xtal;
  logic use_fast_wake;
  logic stab_start;
  logic stab_done;
  logic slow_start;
  logic slow_done;
  logic [CNT_W-1:0] fast_target;
  logic [CNT_W-1:0] slow_target;
  logic [1:0] short_cnt_r;
  logic fast_ready_r;
  logic slow_ready_r;
  logic sub_run_r;

  // Oscillator ticks come from other clocks
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fast_sync_r <= 2'h0;
      slow_sync_r <= 2'h0;
      fast_tick_d_r <= 1'b0;
      slow_tick_d_r <= 1'b0;
    end else begin
      fast_sync_r <= {fast_sync_r[0], fast_osc_tick_in};
      slow_sync_r <= {slow_sync_r[0], slow_osc_tick_in};
      fast_tick_d_r <= fast_sync_r[1];
      slow_tick_d_r <= slow_sync_r[1];
    end
  end
  assign fast_edge = fast_sync_r[1] & ~fast_tick_d_r;
  assign slow_edge = slow_sync_r[1] & ~slow_tick_d_r;

  // Control bits load only on a write and only while running
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_r <= '{clock_divider_select: DIV_RESET, fast_wake_enable: FAST_WAKE_RESET,
                  idle_enable: IDLE_EN_RESET, high_speed_select: HIGH_SEL_RESET,
                  idle_clock_keep: CLK_KEEP_RESET};
    end else if (ctrl_write_in && state_r == MODE_RUN) begin
      ctrl_r.clock_divider_select <= clock_divider_select_in;
      ctrl_r.fast_wake_enable <= fast_wake_enable_in;
      ctrl_r.idle_enable <= idle_enable_in;
      ctrl_r.high_speed_select <= high_speed_select_in;
      ctrl_r.idle_clock_keep <= idle_clock_keep_in;
    end
  end

  assign slow_mode = !ctrl_r.high_speed_select &&
                     (ctrl_r.clock_divider_select == DIV_SLOW_A ||
                      ctrl_r.clock_divider_select == DIV_SLOW_B);
  assign fast_is_xtal = (fast_osc_kind_in == OSC_FAST_XTAL);
  // Fast wake needs the sub clock alive, so deep sleep never uses it
  assign use_fast_wake = ctrl_r.fast_wake_enable && fast_is_xtal && !slow_mode &&
                         (slept_r == MODE_SUB_SLEEP || slept_r == MODE_IDLE_OFF);

  // Mode sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      MODE_RUN: begin
        if (halt_in) begin
          if (ctrl_r.idle_enable) begin
            state_nxt = ctrl_r.idle_clock_keep ? MODE_IDLE_ON : MODE_IDLE_OFF;
          end else if (watchdog_on_in || low_voltage_detector_on_in) begin
            state_nxt = MODE_SUB_SLEEP;
          end else begin
            state_nxt = MODE_DEEP_SLEEP;
          end
        end
      end
      MODE_DEEP_SLEEP, MODE_SUB_SLEEP, MODE_IDLE_OFF, MODE_IDLE_ON: begin
        if (wake_in) begin
          state_nxt = MODE_WAKE;
        end
      end
      MODE_WAKE: begin
        // Resume once the chosen clock is ready
        if (use_fast_wake ? (short_cnt_r == 2'(SHORT_CYCLES)) :
            (slow_mode ? slow_ready_r : fast_ready_r)) begin
          state_nxt = MODE_RUN;
        end
      end
      default: state_nxt = MODE_RUN;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= MODE_RUN;
      slept_r <= MODE_RUN;
    end else begin
      state_r <= state_nxt;
      if (state_r != MODE_WAKE && state_nxt != MODE_RUN && state_nxt != MODE_WAKE) begin
        slept_r <= state_nxt;
      end
    end
  end

  // Stabilisation: 1024 ticks for crystals and fast RC, 1~2 for slow RC
  assign fast_target = (fast_osc_kind_in == OSC_FAST_RC || fast_is_xtal) ?
                       CNT_W'(STAB_CYCLES) : CNT_W'(SHORT_CYCLES);
  assign slow_target = (slow_osc_kind_in == OSC_SLOW_XTAL) ? CNT_W'(STAB_CYCLES) : CNT_W'(SHORT_CYCLES);
  // Clock-on idle keeps the oscillator running, so it needs no count
  assign stab_start = (state_r != MODE_WAKE && state_nxt == MODE_WAKE && slept_r != MODE_IDLE_ON &&
                       !slow_mode) ||
                      (state_r == MODE_RUN && ctrl_write_in && !fast_ready_r &&
                       (high_speed_select_in || clock_divider_select_in > DIV_SLOW_B));
  assign slow_start = state_r != MODE_WAKE && state_nxt == MODE_WAKE && slept_r == MODE_DEEP_SLEEP;

  stab_counter u_fast_stab (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(stab_start),
    .osc_tick_in(fast_edge),
    .target_in(fast_target),
    .done_out(stab_done)
  );

  stab_counter u_slow_stab (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(slow_start),
    .osc_tick_in(slow_edge),
    .target_in(slow_target),
    .done_out(slow_done)
  );

  // Short wait of 1~2 sub clock ticks on fast or clock-on wake
  always_ff @(posedge clk_in) begin
    if (rst_in || state_r != MODE_WAKE) begin
      short_cnt_r <= 2'h0;
    end else if (slow_edge && short_cnt_r != 2'(SHORT_CYCLES)) begin
      short_cnt_r <= short_cnt_r + 2'h1;
    end
  end

  // High-speed ready flag; power-on clears it until the first count ends
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fast_ready_r <= 1'b0;
    end else if (stab_done) begin
      fast_ready_r <= 1'b1;
    end else if (state_r == MODE_DEEP_SLEEP || state_r == MODE_SUB_SLEEP || state_r == MODE_IDLE_OFF ||
                 (state_r == MODE_RUN && state_nxt != MODE_RUN && state_nxt != MODE_IDLE_ON) ||
                 stab_start || (state_r == MODE_RUN && slow_mode)) begin
      fast_ready_r <= 1'b0;
    end else if (state_r == MODE_WAKE && slept_r == MODE_IDLE_ON && short_cnt_r != 2'h0) begin
      fast_ready_r <= 1'b1;
    end
  end

  // Slow ready flag drops only in deep sleep, where the sub clock stops
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      slow_ready_r <= 1'b0;
    end else if (slow_done) begin
      slow_ready_r <= 1'b1;
    end else if (state_r == MODE_DEEP_SLEEP || slow_start) begin
      slow_ready_r <= 1'b0;
    end else if (state_r == MODE_RUN && !slow_ready_r && slow_edge) begin
      slow_ready_r <= 1'b1;
    end
  end

  // Fast wake keeps the core on the sub clock until the crystal count ends
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sub_run_r <= 1'b0;
    end else if (state_r != MODE_WAKE && state_nxt == MODE_WAKE && use_fast_wake) begin
      sub_run_r <= 1'b1;
    end else if (stab_done || slow_mode || (state_r == MODE_RUN && state_nxt != MODE_RUN)) begin
      sub_run_r <= 1'b0;
    end
  end

  // Status flags and watchdog effects on sleep entry
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      power_down_flag_out <= 1'b0;
      watchdog_timeout_clear_out <= 1'b0;
      watchdog_clear_out <= 1'b0;
    end else begin
      watchdog_timeout_clear_out <= state_r == MODE_RUN && state_nxt != MODE_RUN;
      watchdog_clear_out <= state_r == MODE_RUN && state_nxt != MODE_RUN;
      if (state_r == MODE_RUN && state_nxt != MODE_RUN) begin
        power_down_flag_out <= 1'b1;
      end
    end
  end

  // Clock enables and routing
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      clk_ctrl_out <= '0;
      watchdog_stop_out <= 1'b0;
      retain_state_out <= 1'b0;
    end else begin
      clk_ctrl_out.sys_clk_en <= state_nxt == MODE_RUN || state_nxt == MODE_IDLE_ON ||
                                 (state_nxt == MODE_WAKE && use_fast_wake);
      clk_ctrl_out.fast_osc_en <= !slow_mode &&
                                  (state_nxt == MODE_RUN || state_nxt == MODE_WAKE || state_nxt == MODE_IDLE_ON);
      clk_ctrl_out.fast_div_en <= !slow_mode && (state_nxt == MODE_RUN || state_nxt == MODE_IDLE_ON);
      clk_ctrl_out.sub_clk_en <= state_nxt != MODE_DEEP_SLEEP;
      clk_ctrl_out.timebase_en <= state_nxt == MODE_RUN || state_nxt == MODE_IDLE_OFF ||
                                  state_nxt == MODE_IDLE_ON;
      clk_ctrl_out.run_on_sub <= (state_nxt == MODE_WAKE && use_fast_wake) || (sub_run_r && !stab_done) ||
                                 (slow_mode && slow_ready_r);
      clk_ctrl_out.cpu_stall <= state_nxt != MODE_RUN;
      clk_ctrl_out.clk_route <= ctrl_r.high_speed_select ? ROUTE_FAST :
                                (slow_mode ? ROUTE_SLOW : ctrl_r.clock_divider_select);
      watchdog_stop_out <= state_nxt == MODE_DEEP_SLEEP;
      retain_state_out <= state_nxt != MODE_RUN;
    end
  end

  assign high_speed_ready_flag_out = fast_ready_r;
  assign low_speed_ready_flag_out = slow_ready_r;
  assign mode_out = state_r;

  a_deep_sleep_entry: assert property (@(posedge clk_in) disable iff (rst_in)
    state_r == MODE_RUN && halt_in && !ctrl_r.idle_enable && !watchdog_on_in && !low_voltage_detector_on_in
    |=> state_r == MODE_DEEP_SLEEP && !clk_ctrl_out.sub_clk_en && watchdog_stop_out)
    else $error("deep sleep not entered");
  a_sub_sleep_entry: assert property (@(posedge clk_in) disable iff (rst_in)
    state_r == MODE_RUN && halt_in && !ctrl_r.idle_enable && (watchdog_on_in || low_voltage_detector_on_in)
    |=> state_r == MODE_SUB_SLEEP)
    else $error("sub sleep not entered");
  a_idle_choice: assert property (@(posedge clk_in) disable iff (rst_in)
    state_r == MODE_RUN && halt_in && ctrl_r.idle_enable
    |=> state_r == (ctrl_r.idle_clock_keep ? MODE_IDLE_ON : MODE_IDLE_OFF))
    else $error("wrong idle mode");
  a_sleep_flags: assert property (@(posedge clk_in) disable iff (rst_in)
    state_r == MODE_RUN && halt_in |=> power_down_flag_out && watchdog_timeout_clear_out && watchdog_clear_out)
    else $error("sleep flags wrong");
  a_stall_wake: assert property (@(posedge clk_in) disable iff (rst_in)
    state_r == MODE_WAKE |-> clk_ctrl_out.cpu_stall)
    else $error("cpu not stalled in wake");
  a_ready_sleep: assert property (@(posedge clk_in) disable iff (rst_in)
    state_r == MODE_DEEP_SLEEP && !stab_done |=> !high_speed_ready_flag_out)
    else $error("ready flag set in sleep");
  a_slow_stop: assert property (@(posedge clk_in) disable iff (rst_in)
    state_r == MODE_RUN && slow_mode && $stable(slow_mode) |=> !clk_ctrl_out.fast_osc_en && !clk_ctrl_out.fast_div_en)
    else $error("fast osc runs in slow mode");
  a_route_fast: assert property (@(posedge clk_in) disable iff (rst_in)
    ctrl_r.high_speed_select && $stable(ctrl_r) |=> clk_ctrl_out.clk_route == ROUTE_FAST)
    else $error("route not undivided");
  a_deep_no_fast: assert property (@(posedge clk_in) disable iff (rst_in)
    slept_r == MODE_DEEP_SLEEP && state_r == MODE_WAKE && !slow_mode |-> !clk_ctrl_out.run_on_sub)
    else $error("fast wake from deep sleep");
  a_fast_wake_sub: assert property (@(posedge clk_in) disable iff (rst_in)
    state_r == MODE_WAKE && use_fast_wake |-> clk_ctrl_out.run_on_sub && clk_ctrl_out.sys_clk_en)
    else $error("fast wake not on sub clock");
  a_sub_handover: assert property (@(posedge clk_in) disable iff (rst_in)
    state_r == MODE_RUN && sub_run_r && stab_done && !slow_mode
    |=> high_speed_ready_flag_out && !clk_ctrl_out.run_on_sub)
    else $error("no handover to crystal");
  a_ready_drop: assert property (@(posedge clk_in) disable iff (rst_in)
    state_r == MODE_RUN && halt_in && !(ctrl_r.idle_enable && ctrl_r.idle_clock_keep) && !stab_done
    |=> !high_speed_ready_flag_out)
    else $error("ready flag kept on sleep entry");
endmodule : power_mode_wakeup_control
`default_nettype wire

// ### verification/power_mode_wakeup_control_bench.sv
// Self-checking bench for the power mode and wake-up controller
`timescale 1ns/1ns
`default_nettype none
`define CHECK(g, e) check_eq(16'(g), 16'(e))
module power_mode_wakeup_control_bench
  import pwr_mode_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [2:0] clock_divider_select_in = 3'h0;
  logic fast_wake_enable_in = 1'b0;
  logic idle_enable_in = 1'b1;
  logic high_speed_select_in = 1'b1;
  logic idle_clock_keep_in = 1'b0;
  logic ctrl_write_in = 1'b0;
  osc_kind_t fast_osc_kind_in = OSC_FAST_XTAL;
  osc_kind_t slow_osc_kind_in = OSC_SLOW_RC;
  logic watchdog_on_in = 1'b0;
  logic low_voltage_detector_on_in = 1'b0;
  logic halt_in = 1'b0;
  logic wake_in = 1'b0;
  logic fast_osc_tick_in = 1'b0;
  logic slow_osc_tick_in = 1'b0;
  logic [3:0] slow_cnt = 4'h0;
  logic high_speed_ready_flag_out, low_speed_ready_flag_out, power_down_flag_out;
  logic watchdog_timeout_clear_out, watchdog_clear_out, watchdog_stop_out, retain_state_out;
  pwr_state_t mode_out;
  clk_ctrl_t clk_ctrl_out;
  int unsigned fail_count = 0;
  int unsigned tests_run = 0;
  int unsigned n;

  power_mode_wakeup_control i_power_mode_wakeup_control (
    .clk_in(clk_in), .rst_in(rst_in),
    .clock_divider_select_in(clock_divider_select_in), .fast_wake_enable_in(fast_wake_enable_in),
    .idle_enable_in(idle_enable_in), .high_speed_select_in(high_speed_select_in),
    .idle_clock_keep_in(idle_clock_keep_in), .ctrl_write_in(ctrl_write_in),
    .fast_osc_kind_in(fast_osc_kind_in), .slow_osc_kind_in(slow_osc_kind_in),
    .watchdog_on_in(watchdog_on_in), .low_voltage_detector_on_in(low_voltage_detector_on_in),
    .halt_in(halt_in), .wake_in(wake_in),
    .fast_osc_tick_in(fast_osc_tick_in), .slow_osc_tick_in(slow_osc_tick_in),
    .high_speed_ready_flag_out(high_speed_ready_flag_out), .low_speed_ready_flag_out(low_speed_ready_flag_out),
    .power_down_flag_out(power_down_flag_out), .watchdog_timeout_clear_out(watchdog_timeout_clear_out),
    .watchdog_clear_out(watchdog_clear_out), .watchdog_stop_out(watchdog_stop_out),
    .retain_state_out(retain_state_out), .mode_out(mode_out), .clk_ctrl_out(clk_ctrl_out)
  );

  initial begin
    forever #25 clk_in = ~clk_in;
  end

  // Fast oscillator at half the bus rate keeps 1024-edge counts short; slow one at 1/16
  always @(posedge clk_in) begin
    fast_osc_tick_in <= ~fast_osc_tick_in;
    slow_cnt <= slow_cnt + 4'h1;
    slow_osc_tick_in <= slow_cnt[3];
  end

  task automatic check_eq(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : check_eq

  task automatic print_verdict;
    $display("Comparisons: %0d, mismatches: %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  task automatic write_ctrl(input logic [2:0] div, input logic fw, ie, hs, keep);
    @(posedge clk_in);
    clock_divider_select_in <= div;
    fast_wake_enable_in <= fw;
    idle_enable_in <= ie;
    high_speed_select_in <= hs;
    idle_clock_keep_in <= keep;
    ctrl_write_in <= 1'b1;
    @(posedge clk_in);
    ctrl_write_in <= 1'b0;
  endtask : write_ctrl

  // Sampled 1 ns after the edge that answers the pulse
  task automatic pulse(input logic h, input logic w);
    @(posedge clk_in);
    halt_in <= h;
    wake_in <= w;
    @(posedge clk_in);
    halt_in <= 1'b0;
    wake_in <= 1'b0;
    #1;
  endtask : pulse

  function automatic logic [15:0] probe(input int unsigned which);
    case (which)
      0: probe = 16'(mode_out);
      1: probe = 16'(high_speed_ready_flag_out);
      default: probe = 16'(clk_ctrl_out.clk_route);
    endcase
  endfunction : probe

  task automatic wait_for(input int unsigned which, input logic [15:0] exp, input int unsigned bound);
    logic hit;
    hit = 1'b0;
    for (n = 1; n <= bound && !hit; n++) begin
      @(posedge clk_in);
      #1;
      hit = (probe(which) === exp);
    end
    n = n - 1;
    if (!hit) begin
      fail_count++;
      $display("ERROR at %0t ns: wait on probe %0d timed out", $time, which);
      print_verdict();
    end
  endtask : wait_for

  task automatic sleep(input logic fw, ie, keep, wd, low_voltage_detector, input pwr_state_t m);
    write_ctrl(3'h0, fw, ie, 1'b1, keep);
    watchdog_on_in <= wd;
    low_voltage_detector_on_in <= low_voltage_detector;
    pulse(1'b1, 1'b0);
    `CHECK(mode_out, m);
    `CHECK({power_down_flag_out, watchdog_timeout_clear_out}, 2'h3);
    `CHECK({retain_state_out, clk_ctrl_out.cpu_stall, clk_ctrl_out.sys_clk_en}, {2'h3, m == MODE_IDLE_ON});
  endtask : sleep

  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    `CHECK({mode_out, power_down_flag_out, high_speed_ready_flag_out}, {MODE_RUN, 2'h0});
    write_ctrl(3'h0, 1'b0, 1'b0, 1'b1, 1'b0);
    wait_for(1, 16'h1, 2200);
    wait_for(2, 16'(ROUTE_FAST), 4);
    // Select bit zero: both slow codes, then every divided code
    for (int d = 0; d < 9; d++) begin
      write_ctrl(d < 8 ? 3'(d) : DIV_SLOW_B, 1'b0, 1'b0, 1'b0, 1'b0);
      wait_for(2, d < 2 || d == 8 ? 16'(ROUTE_SLOW) : 16'(d), 2200);
      if (d < 2 || d == 8) begin
        `CHECK({low_speed_ready_flag_out, clk_ctrl_out.fast_osc_en, clk_ctrl_out.fast_div_en}, 3'h4);
      end else begin
        wait_for(1, 16'h1, 2200);
        `CHECK({high_speed_ready_flag_out, clk_ctrl_out.fast_osc_en}, 2'h3);
      end
    end
    write_ctrl(3'h0, 1'b0, 1'b0, 1'b1, 1'b0);
    wait_for(1, 16'h1, 2200);
    // Deep sleep; fast wake enable must not matter
    sleep(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, MODE_DEEP_SLEEP);
    `CHECK({watchdog_stop_out, watchdog_clear_out, clk_ctrl_out.sub_clk_en}, 3'h6);
    `CHECK({clk_ctrl_out.timebase_en, high_speed_ready_flag_out}, 2'h0);
    pulse(1'b1, 1'b0);
    `CHECK(mode_out, MODE_DEEP_SLEEP);
    pulse(1'b0, 1'b1);
    `CHECK({mode_out, clk_ctrl_out.cpu_stall, clk_ctrl_out.run_on_sub}, {MODE_WAKE, 2'h2});
    wait_for(1, 16'h1, 2200);
    `CHECK(n >= 2030 && n <= 2070, 1'b1);
    `CHECK(clk_ctrl_out.run_on_sub, 1'b0);
    wait_for(0, 16'(MODE_RUN), 4);
    `CHECK(clk_ctrl_out.cpu_stall, 1'b0);
    // Sub-clock sleep, crystal with fast wake
    sleep(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, MODE_SUB_SLEEP);
    `CHECK({clk_ctrl_out.sub_clk_en, clk_ctrl_out.timebase_en, watchdog_stop_out}, 3'h4);
    pulse(1'b0, 1'b1);
    wait_for(0, 16'(MODE_RUN), 80);
    `CHECK({clk_ctrl_out.run_on_sub, high_speed_ready_flag_out}, 2'h2);
    wait_for(1, 16'h1, 2200);
    `CHECK(clk_ctrl_out.run_on_sub, 1'b0);
    // Clock-off idle also offers fast wake
    sleep(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, MODE_IDLE_OFF);
    `CHECK(high_speed_ready_flag_out, 1'b0);
    pulse(1'b0, 1'b1);
    wait_for(0, 16'(MODE_RUN), 80);
    `CHECK(clk_ctrl_out.run_on_sub, 1'b1);
    wait_for(1, 16'h1, 2200);
    // Clock-on idle keeps the oscillator, so wake is short
    sleep(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, MODE_IDLE_ON);
    `CHECK({high_speed_ready_flag_out, clk_ctrl_out.fast_osc_en}, 2'h3);
    pulse(1'b0, 1'b1);
    wait_for(0, 16'(MODE_RUN), 40);
    `CHECK(high_speed_ready_flag_out, 1'b1);
    // Fast RC ignores fast wake enable
    @(posedge clk_in);
    fast_osc_kind_in <= OSC_FAST_RC;
    sleep(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, MODE_SUB_SLEEP);
    pulse(1'b0, 1'b1);
    `CHECK(clk_ctrl_out.run_on_sub, 1'b0);
    wait_for(1, 16'h1, 2200);
    `CHECK(n >= 2030 && n <= 2070, 1'b1);
    wait_for(0, 16'(MODE_RUN), 4);
    print_verdict();
  end
endmodule : power_mode_wakeup_control_bench
`default_nettype wire
